// ### include/prs_pkg.sv
/*
 * shared constants, state codes and carriers of the power-on / run-enable reset
 * sequencer. assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package prs_pkg;

    ////////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_KHZ         = 100000;
    localparam int LEVEL_WAIT_MS   = 50;
    localparam int CARRY_PERIOD_MS = 100;
    localparam int CARRY_SHORT_MS  = 5;
    localparam int LEVEL_CYCLES    = LEVEL_WAIT_MS * CLK_KHZ;
    localparam int CARRY_CYCLES    = CARRY_PERIOD_MS * CLK_KHZ;
    localparam int SHORT_CYCLES    = CARRY_SHORT_MS * CLK_KHZ;

    ////////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] CARRY_IDX   = 8'h17;
    localparam logic [7:0] CARRY_ADDR  = 8'(CARRY_IDX * 4);
    localparam int CTRL_STOP_BIT  = 0;
    localparam int CTRL_SHORT_BIT = 1;
    localparam int CARRY_FLAG_BIT = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [13:0] START_ADDRESS = 14'h0000;

    typedef enum logic [1:0] {
        PRS_SEL_CTRL   = 2'h0,
        PRS_SEL_STATUS = 2'h1,
        PRS_SEL_CARRY  = 2'h2,
        PRS_SEL_NONE   = 2'h3
    } prs_sel_t;

    typedef enum logic [5:0] {
        PRS_CLEAR    = 6'b000001,
        PRS_WAIT     = 6'b000010,
        PRS_RUN      = 6'b000100,
        PRS_CEWAIT   = 6'b001000,
        PRS_STOP     = 6'b010000,
        PRS_STOPEXIT = 6'b100000
    } prs_state_t;

    // what the core and the analog detector see
    typedef struct packed {
        logic        core_reset;
        logic        core_halt;
        logic        start_pulse;
        logic [13:0] start_address;
        logic        osc_enable;
        logic        normal_level;
    } prs_core_t;

    // status word, low bits of the status register
    typedef struct packed {
        logic ce_pending;
        logic carry_disable;
        logic normal_level;
        logic clock_stop;
        logic core_halt;
        logic osc_enable;
        logic power_clear;
    } prs_status_t;

endpackage

// ### rtl/prs_carry_gen.sv
/*
 * timer carry setting pulse generator: one-cycle pulse every period cycles.
 * assumes the period input holds steady between pulses.
 */
`timescale 1ns/1ns
module prs_carry_gen #(
    parameter int MAX_PERIOD = prs_pkg::CARRY_CYCLES
) (
    input  wire logic        aclk,     // system clock
    input  wire logic        aresetn,  // synchronous reset, active low
    input  wire logic        restart,  // hold to restart at half a period
    input  wire logic [31:0] period,   // period in cycles
    output logic             pulse     // carry setting pulse
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        pulse;
    } prs_gen_t;

    prs_gen_t s;
    prs_gen_t next_s;

    if (MAX_PERIOD < 4) begin : g_chk
        $error("carry period too short");
    end

    always_comb begin
        next_s = s;
        next_s.pulse = 1'b0;
        if (restart) begin
            // half period: first pulse lands mid-way, as the power-on wait needs
            next_s.cnt = period >> 1;
        end else if (s.cnt == 32'h0) begin
            next_s.cnt = period - 32'h1;
            next_s.pulse = 1'b1;
        end else begin
            next_s.cnt = s.cnt - 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse = s.pulse;
endmodule // prs_carry_gen

// ### rtl/prs_seq.sv
/*
 * power-on and run-enable reset sequencer with timer carry flag and disable
 * flop, reached over AXI4-Lite. assumes run_enable is synchronous to aclk and
 * power_clear_in comes unsynchronised from the voltage detector.
 */
`timescale 1ns/1ns
module prs_seq #(
    parameter int LEVEL_CYCLES = prs_pkg::LEVEL_CYCLES,
    parameter int CARRY_CYCLES = prs_pkg::CARRY_CYCLES,
    parameter int SHORT_CYCLES = prs_pkg::SHORT_CYCLES
) (
    input  wire logic               aclk,           // system clock
    input  wire logic               aresetn,        // synchronous reset, active low
    input  wire logic               power_clear_in, // detector output, high = clear
    input  wire logic               run_enable,     // run-enable pin
    output prs_pkg::prs_core_t      core,           // core control, registered
    input  wire logic [7:0]         awaddr,         // write address
    input  wire logic               awvalid,        // write address valid
    output logic                    awready,        // write address ready
    input  wire logic [31:0]        wdata,          // write data
    input  wire logic [3:0]         wstrb,          // write strobes
    input  wire logic               wvalid,         // write data valid
    output logic                    wready,         // write data ready
    output logic [1:0]              bresp,          // write response
    output logic                    bvalid,         // write response valid
    input  wire logic               bready,         // write response ready
    input  wire logic [7:0]         araddr,         // read address
    input  wire logic               arvalid,        // read address valid
    output logic                    arready,        // read address ready
    output logic [31:0]             rdata,          // read data
    output logic [1:0]              rresp,          // read response
    output logic                    rvalid,         // read data valid
    input  wire logic               rready          // read data ready
);
    typedef struct packed {
        prs_pkg::prs_state_t fst;
        logic [1:0]          sync;
        logic                ce_d;
        logic [31:0]         cnt;
        logic                flag;
        logic                dis;
        logic                short_sel;
        logic                stop_req;
        prs_pkg::prs_core_t  core;
        logic                aw_got;
        logic                w_got;
        logic [7:0]          aw_q;
        logic [31:0]         w_q;
        logic                w_low_lane;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
    } prs_seq_st_t;

    prs_seq_st_t s;
    prs_seq_st_t next_s;
    logic        carry_pulse;
    logic [31:0] carry_period;
    logic        pc;
    logic        ce_rise;

    if (LEVEL_CYCLES < 2 || SHORT_CYCLES < 4 || CARRY_CYCLES < SHORT_CYCLES) begin : g_chk
        $error("sequencer timing parameters out of range");
    end

    function automatic prs_pkg::prs_sel_t decode(input logic [7:0] addr);
        case (addr)
            prs_pkg::CTRL_ADDR:   decode = prs_pkg::PRS_SEL_CTRL;
            prs_pkg::STATUS_ADDR: decode = prs_pkg::PRS_SEL_STATUS;
            prs_pkg::CARRY_ADDR:  decode = prs_pkg::PRS_SEL_CARRY;
            default:              decode = prs_pkg::PRS_SEL_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // carry pulse source, restarted while power clear holds

    assign carry_period = s.short_sel ? 32'(SHORT_CYCLES) : 32'(CARRY_CYCLES);

    prs_carry_gen #(
        .MAX_PERIOD (CARRY_CYCLES)
    ) u_carry (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (s.fst == prs_pkg::PRS_CLEAR),
        .period  (carry_period),
        .pulse   (carry_pulse)
    );

    assign pc = s.sync[1];
    assign ce_rise = run_enable && !s.ce_d;

    ////////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        prs_pkg::prs_sel_t rsel;
        rsel = decode(araddr);
        next_s = s;
        next_s.sync = {s.sync[0], power_clear_in};
        next_s.ce_d = run_enable;

        // register bus, write side: address and data in either order
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_q = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.w_q = wdata;
            // strobe kept with its data: the master may change it once w is taken
            next_s.w_low_lane = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = prs_pkg::RESP_OKAY;
            case (decode(s.aw_q))
                prs_pkg::PRS_SEL_CTRL: begin
                    if (s.w_low_lane) begin
                        next_s.stop_req = s.w_q[prs_pkg::CTRL_STOP_BIT];
                        next_s.short_sel = s.w_q[prs_pkg::CTRL_SHORT_BIT];
                    end
                end
                prs_pkg::PRS_SEL_STATUS,
                prs_pkg::PRS_SEL_CARRY: begin
                end
                default: next_s.bresp = prs_pkg::RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // read side
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = prs_pkg::RESP_OKAY;
            next_s.rdata = 32'h0;
            case (rsel)
                prs_pkg::PRS_SEL_CTRL: begin
                    next_s.rdata[prs_pkg::CTRL_SHORT_BIT] = s.short_sel;
                end
                prs_pkg::PRS_SEL_STATUS: begin
                    next_s.rdata = 32'(prs_pkg::prs_status_t'{
                        ce_pending:    s.fst == prs_pkg::PRS_CEWAIT,
                        carry_disable: s.dis,
                        normal_level:  s.core.normal_level,
                        clock_stop:    s.fst == prs_pkg::PRS_STOP,
                        core_halt:     s.core.core_halt,
                        osc_enable:    s.core.osc_enable,
                        power_clear:   pc});
                end
                prs_pkg::PRS_SEL_CARRY: begin
                    next_s.rdata[prs_pkg::CARRY_FLAG_BIT] = s.flag;
                    next_s.flag = 1'b0;
                    next_s.dis = 1'b0;
                end
                default: next_s.rresp = prs_pkg::RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // carry flag: a pulse in the cycle of the read still sets it
        if (carry_pulse && !s.dis) begin
            next_s.flag = 1'b1;
        end

        // sequencer
        next_s.core.start_pulse = 1'b0;
        case (s.fst)
            prs_pkg::PRS_CLEAR: begin
                if (!pc) begin
                    next_s.fst = prs_pkg::PRS_WAIT;
                end
            end
            prs_pkg::PRS_WAIT: begin
                // a run-enable rise here merges into the power-on start
                if (carry_pulse) begin
                    next_s.fst = prs_pkg::PRS_RUN;
                    next_s.core.start_pulse = 1'b1;
                end
            end
            prs_pkg::PRS_RUN: begin
                if (ce_rise) begin
                    next_s.fst = prs_pkg::PRS_CEWAIT;
                end else if (s.stop_req) begin
                    next_s.fst = prs_pkg::PRS_STOP;
                    next_s.stop_req = 1'b0;
                end
            end
            prs_pkg::PRS_CEWAIT: begin
                if (carry_pulse) begin
                    next_s.fst = prs_pkg::PRS_RUN;
                    next_s.core.start_pulse = 1'b1;
                end
            end
            prs_pkg::PRS_STOP: begin
                if (ce_rise) begin
                    next_s.fst = prs_pkg::PRS_STOPEXIT;
                    next_s.cnt = 32'h0;
                end
            end
            prs_pkg::PRS_STOPEXIT: begin
                // supply still low at the switch shows up as power clear next
                next_s.cnt = s.cnt + 32'h1;
                if (s.cnt == 32'(LEVEL_CYCLES - 1)) begin
                    next_s.fst = prs_pkg::PRS_CEWAIT;
                end
            end
            default: next_s.fst = prs_pkg::PRS_CLEAR;
        endcase

        if (pc) begin
            next_s.fst = prs_pkg::PRS_CLEAR;
            next_s.dis = 1'b1;
            next_s.flag = 1'b0;
            next_s.stop_req = 1'b0;
            next_s.short_sel = 1'b0;
            next_s.core.start_pulse = 1'b0;
        end

        next_s.core.core_reset = next_s.fst == prs_pkg::PRS_CLEAR;
        next_s.core.core_halt = next_s.fst inside {prs_pkg::PRS_CLEAR, prs_pkg::PRS_WAIT,
                                                   prs_pkg::PRS_CEWAIT};
        next_s.core.osc_enable = !(next_s.fst inside {prs_pkg::PRS_CLEAR,
                                                      prs_pkg::PRS_STOP});
        next_s.core.normal_level = !(next_s.fst inside {prs_pkg::PRS_STOP,
                                                        prs_pkg::PRS_STOPEXIT});
        next_s.core.start_address = prs_pkg::START_ADDRESS;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.fst <= prs_pkg::PRS_CLEAR;
            // power clear assumed until the pin is seen low, so no start slips out of reset
            s.sync <= 2'h3;
            s.dis <= 1'b1;
            s.core.core_reset <= 1'b1;
            s.core.core_halt <= 1'b1;
            s.core.normal_level <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign core = s.core;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;

    ////////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    clear_holds_a: assert property (pc |=> s.fst == prs_pkg::PRS_CLEAR && core.core_reset)
        else $error("power clear did not hold reset");
    osc_release_a: assert property ($rose(core.osc_enable) |-> !$past(pc))
        else $error("oscillator started under power clear");
    first_start_a: assert property (s.fst == prs_pkg::PRS_WAIT && carry_pulse && !pc
        |=> core.start_pulse && core.start_address == prs_pkg::START_ADDRESS
        && !core.core_halt)
        else $error("power-on start missing");
    single_start_a: assert property (core.start_pulse |=> !core.start_pulse)
        else $error("start pulse longer than one cycle");
    ce_restart_a: assert property (s.fst == prs_pkg::PRS_RUN && ce_rise && !pc
        |=> core.core_halt && !core.start_pulse)
        else $error("run-enable restart not deferred to carry");
    start_on_carry_a: assert property (core.start_pulse |-> $past(carry_pulse))
        else $error("start pulse without a carry pulse");
    stop_exit_a: assert property (s.fst == prs_pkg::PRS_STOP && ce_rise && !pc
        |=> core.osc_enable && !core.normal_level)
        else $error("clock stop not left on run-enable");
    level_switch_a: assert property ($rose(core.normal_level) && !pc |->
        $past(s.fst == prs_pkg::PRS_STOPEXIT && s.cnt == 32'(LEVEL_CYCLES - 1)))
        else $error("detect level switched at wrong time");
    stop_level_a: assert property (s.fst == prs_pkg::PRS_STOP |-> !core.normal_level
        && !core.osc_enable)
        else $error("stopped with normal detect level");
    disable_set_a: assert property (pc |=> s.dis && !s.flag)
        else $error("power clear left carry enabled");
    flag_blocked_a: assert property (s.dis && !s.flag && !(arvalid && arready)
        |=> !s.flag)
        else $error("carry flag set while disabled");
    flag_sets_a: assert property (carry_pulse && !s.dis && !pc |=> s.flag)
        else $error("carry pulse lost");
    sync_delay_a: assert property ($rose(power_clear_in) ##1 power_clear_in
        |=> pc)
        else $error("power clear synchroniser delay wrong");

    power_on_c: cover property (s.fst == prs_pkg::PRS_WAIT ##1 core.start_pulse);
    ce_reset_c: cover property (s.fst == prs_pkg::PRS_CEWAIT ##1 core.start_pulse);
    stop_exit_c: cover property (s.fst == prs_pkg::PRS_STOPEXIT
        ##1 s.fst == prs_pkg::PRS_CEWAIT);
    flag_read_c: cover property (s.flag && arvalid && arready
        && araddr == prs_pkg::CARRY_ADDR);
endmodule // prs_seq

// ### tb/prs_detector_model.sv
/*
 * far-side model: the supply voltage detector that drives the power clear input.
 * assumes the bench sets the supply in millivolts and the design selects the level.
 */
`timescale 1ns/1ns
module prs_detector_model #(
    parameter logic [15:0] NORMAL_MV = 16'h0dac, // 3.5 V level
    parameter logic [15:0] STOP_MV   = 16'h0898  // 2.2 V level
) (
    input  wire logic [15:0] supply_mv,    // supply in millivolts
    input  wire logic        normal_level, // level select from the design
    output logic             power_clear   // high while supply is below level
);
    // analog comparator without hysteresis, so a slow ramp gives one clean edge
    assign power_clear = supply_mv < (normal_level ? NORMAL_MV : STOP_MV);
endmodule // prs_detector_model

// ### tb/prs_seq_tb.sv
/*
 * self-checking bench of the reset sequencer: power-up, run-enable restart,
 * clock stop exit and the timer carry flag, seen through AXI4-Lite and the core port.
 * assumes shortened count parameters and the detector model as far side.
 */
`timescale 1ns/1ns
module prs_seq_tb;
    localparam int LV = 20;
    localparam int CY = 40;
    localparam int SH = 8;
    logic        aclk       = 1'b0;
    logic        aresetn    = 1'b0;
    logic        run_enable = 1'b0;
    logic [15:0] supply_mv  = 16'h0000;
    logic [7:0]  awaddr     = 8'h00;
    logic [7:0]  araddr     = 8'h00;
    logic [31:0] wdata      = 32'h0;
    logic        awvalid    = 1'b0;
    logic        wvalid     = 1'b0;
    logic        bready     = 1'b0;
    logic        arvalid    = 1'b0;
    logic        rready     = 1'b0;
    logic [3:0]  wstrb      = 4'hf;
    logic        power_clear_in, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    prs_pkg::prs_core_t core;
    int          seed        = 54;
    int          miscompares = 0;
    int          checks_done = 0;
    int          starts      = 0;
    int          cyc         = 0;
    int          last_start  = 0;

    always #5 aclk = ~aclk;

    prs_seq #(.LEVEL_CYCLES(LV), .CARRY_CYCLES(CY), .SHORT_CYCLES(SH)) dut (
        .aclk(aclk), .aresetn(aresetn), .power_clear_in(power_clear_in),
        .run_enable(run_enable), .core(core), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    prs_detector_model far_side (
        .supply_mv(supply_mv), .normal_level(core.normal_level), .power_clear(power_clear_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // firmware view: a clear flag at detection time means the supply was lost
    function automatic logic power_failed(input logic flag);
        return !flag;
    endfunction

    // the other way to tell: marker nibbles in data memory survive a run-enable reset
    function automatic logic ram_backed(input logic [7:0] m);
        return m == 8'ha6;
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        // ready left high: legal, and no second drive of it in one time step
        r = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    // raise the supply; ce_at < 0 raises run-enable together with it
    task automatic power_up(input int ce_at);
        int n;
        supply_mv <= 16'h0dac + 16'($unsigned($random(seed)) % 2000);
        if (ce_at < 0) run_enable <= 1'b1;
        for (n = 0; n < 4 * CY && core.start_pulse !== 1'b1; n++) begin
            @(posedge aclk);
            if (n == ce_at) run_enable <= 1'b1;
        end
        check(n >= CY / 2 && n <= CY / 2 + 8, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (core.start_pulse === 1'b1) begin
            starts     <= starts + 1;
            last_start <= cyc;
            check(32'(core.start_address), 32'h0);
        end
    end

    initial begin
        tick(40 * CY);
        miscompares++;
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic [31:0] w;
        logic [1:0]  r;
        int          s0;
        int          n;
        logic [7:0]  marks;
        tick(16);
        aresetn <= 1'b1;
        tick(2);
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[2:0], 3'b101);
        check(core.core_reset, 1'b1);
        s0 = starts;
        power_up(-1);
        tick(4);
        check(starts - s0, 1);
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[5], 1'b1);
        // detection read comes well before the next carry pulse after the start
        axi_rd(prs_pkg::CARRY_ADDR, d, r);
        check(cyc - last_start < CY, 1'b1);
        check(d[0], 1'b0);
        check(power_failed(d[0]), 1'b1);
        marks = 8'ha6;
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[5], 1'b0);
        tick(CY + 4);
        axi_rd(prs_pkg::CARRY_ADDR, d, r);
        check(d[0], 1'b1);
        axi_rd(prs_pkg::CARRY_ADDR, d, r);
        check(d[0], 1'b0);
        // line up just after a carry pulse so the pending restart stays visible
        while ((cyc - last_start) % CY != 5) @(posedge aclk);
        run_enable <= 1'b0;
        tick(2);
        run_enable <= 1'b1;
        tick(3);
        check(core.core_halt, 1'b1);
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[6], 1'b1);
        for (n = 0; n < 4 * CY && core.start_pulse !== 1'b1; n++) @(posedge aclk);
        check(n <= CY, 1'b1);
        tick(2);
        axi_rd(prs_pkg::CARRY_ADDR, d, r);
        check(power_failed(d[0]), 1'b0);
        check(cyc - last_start < CY, 1'b1);
        check(ram_backed(marks), !power_failed(d[0]));
        w = $random(seed);
        w[0] = 1'b0;
        axi_wr(prs_pkg::CTRL_ADDR, w, r);
        check(r, prs_pkg::RESP_OKAY);
        axi_rd(prs_pkg::CTRL_ADDR, d, r);
        check(d[1:0], {w[1], 1'b0});
        // no strobe on the low lane: the control bits must stay as they are
        wstrb <= 4'h0;
        axi_wr(prs_pkg::CTRL_ADDR, w ^ 32'h3, r);
        wstrb <= 4'hf;
        axi_rd(prs_pkg::CTRL_ADDR, d, r);
        check(d[1:0], {w[1], 1'b0});
        axi_wr(prs_pkg::CTRL_ADDR, 32'h1, r);
        tick(3);
        check({core.osc_enable, core.normal_level}, 2'b00);
        supply_mv <= 16'h0898 + 16'($unsigned($random(seed)) % 1300);
        tick(6);
        check(core.core_reset, 1'b0);
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[3], 1'b1);
        run_enable <= 1'b0;
        tick(2);
        run_enable <= 1'b1;
        for (n = 0; n < 4 * LV && core.normal_level !== 1'b1; n++) begin
            @(posedge aclk);
            if (n == 4) check(core.osc_enable, 1'b1);
        end
        check(n >= LV && n <= LV + 4, 1'b1);
        tick(6);
        check({core.core_reset, core.osc_enable}, 2'b10);
        axi_rd(prs_pkg::STATUS_ADDR, d, r);
        check(d[5], 1'b1);
        axi_rd(prs_pkg::CTRL_ADDR, d, r);
        check(d[1:0], 2'b00);
        run_enable <= 1'b0;
        s0 = starts;
        power_up(6);
        tick(4);
        check(starts - s0, 1);
        tick(CY + 4);
        axi_rd(prs_pkg::CARRY_ADDR, d, r);
        check(d[0], 1'b0);
        axi_wr(8'h40, 32'h0, r);
        check(r, prs_pkg::RESP_SLVERR);
        axi_rd(8'h40, d, r);
        check(r, prs_pkg::RESP_SLVERR);
        check(d, 32'h0);
        wrap_up();
    end
endmodule // prs_seq_tb
